// ===== hdl/lds_fifo.sv
`timescale 1ns/1ns
module lds_fifo
  import lds_pkg::*;
#(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
)(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  // pointer wrap relies on a power of two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("lds_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  logic [WIDTH-1:0] out_ff;
  logic vld_ff;
  wire empty = (wr_ff == rd_ff);
  wire full = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  wire push = i_valid && !full;
  // output register refills when empty or consumed
  wire pop = !empty && (!vld_ff || i_ready);
  assign o_ready = !full;
  assign o_valid = vld_ff;
  assign o_data = out_ff;
  // storage has no reset; pointers guard it
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem_ff[wr_ff[AW-1:0]] <= i_data;
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
      vld_ff <= 1'b0;
      out_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ff <= wr_ff + 1'b1;
      if (pop)
      begin
        rd_ff <= rd_ff + 1'b1;
        out_ff <= mem_ff[rd_ff[AW-1:0]];
        vld_ff <= 1'b1;
      end
      else if (i_ready)
        vld_ff <= 1'b0;
    end
  end
endmodule

// ===== hdl/lds_pkg.sv
package lds_pkg;
  // register indices
  localparam logic [4:0] REG_MODE_CONFIG_ONE = 5'h00;
  localparam logic [4:0] REG_MODE_CONFIG_TWO = 5'h01;
  localparam logic [4:0] REG_DUTY_FIRST = 5'h02;
  localparam logic [4:0] REG_DUTY_LAST = 5'h11;
  localparam logic [4:0] REG_GRP_FIRST = 5'h12;
  localparam logic [4:0] REG_GRP_LAST = 5'h13;
  localparam logic [4:0] REG_GROUP_ONE_ENABLE_BIT = 5'h18;
  localparam logic [4:0] REG_GROUP_TWO_ENABLE_BIT = 5'h19;
  localparam logic [4:0] REG_GROUP_THREE_ENABLE_BIT = 5'h1a;
  localparam logic [4:0] REG_BCAST = 5'h1b;
  localparam logic [4:0] REG_LAST = 5'h1b;
  localparam int NUM_REGS = 32;
  // reset values
  localparam logic [7:0] RST_MODE_CONFIG_ONE = 8'h11;
  localparam logic [7:0] RST_GROUP_ONE_ENABLE_BIT = 8'hd2;
  localparam logic [7:0] RST_GROUP_TWO_ENABLE_BIT = 8'hd4;
  localparam logic [7:0] RST_GROUP_THREE_ENABLE_BIT = 8'hd8;
  localparam logic [7:0] RST_BCAST = 8'hd0;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // reserved soft reset address and key bytes
  localparam logic [6:0] SOFT_RESET_ADDR = 7'h6b;
  localparam logic [7:0] SOFT_KEY_ONE = 8'ha5;
  localparam logic [7:0] SOFT_KEY_TWO = 8'h5a;
  // mode_config_one enable bit positions
  localparam int BIT_BCAST_EN = 0;
  localparam int BIT_GROUP_THREE_ENABLE_BIT_EN = 1;
  localparam int BIT_GROUP_TWO_ENABLE_BIT_EN = 2;
  localparam int BIT_GROUP_ONE_ENABLE_BIT_EN = 3;
  // increment options
  localparam logic [2:0] INC_NONE = 3'h0;
  localparam logic [2:0] INC_ALL = 3'h4;
  localparam logic [2:0] INC_DUTY = 3'h5;
  localparam logic [2:0] INC_GRP = 3'h6;
  localparam logic [2:0] INC_DUTY_GRP = 3'h7;
  localparam int BIT_INC_EN = 7;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
endpackage

// ===== hdl/lds_slave.sv
// How it works
// - sda fall with scl high is start
// - sda rise with scl high is stop
// - one bit per pulse, sampled scl high
// - eight bits then one ack slot
// - no byte count limit per transfer
// - ack by holding sda low through slot
// - master nack on read releases sda
// - address lsb one reads, zero writes
// - broadcast address d0, enabled, both directions
// - group addresses reset d2 d4 d8, writable
// - group addresses disabled after power up
// - soft reset address acked on write only
// - first write byte is pointer control
// - control bits 4:0 pointer, 7:5 option
// - enabled increment steps pointer, keeps option
// - option 000 holds pointer fixed
// - option 100 wraps 1b to 00
// - option 101 wraps 11 to 02
// - option 110 wraps 13 to 12
// - option 111 wraps 13 to 02
// - above range, count to 1b, wrap 00
// - soft reset acks only a5 then 5a
// - reset to defaults after keys and stop
// - mode one bits enable group, broadcast responses
`timescale 1ns/1ns
module lds_slave
  import lds_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h60,
  parameter int FIFO_DEPTH = 8
)(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  output logic o_wr_valid,
  output logic [4:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  input wire logic i_wr_ready,
  output logic [7:0] o_mode_config_one,
  output logic o_busy
);
  typedef enum {ST_IDLE, ST_ADDR, ST_CTRL, ST_WDATA, ST_RDATA, ST_KEY1, ST_KEY2,
    ST_KEYDONE, ST_IGNORE} lds_state_e;
  // pins cross two flops before use
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic scl_ff;
  logic sda_ff;
  lds_state_e state_ff;
  lds_state_e nxt_state;
  logic [7:0] shift_ff;
  logic [3:0] bitcnt_ff;
  logic [7:0] ctrl_ff;
  logic ack_ff;
  logic rd_ack_ff;
  logic sda_oe_ff;
  logic soft_armed_ff;
  logic soft_req_ff;
  logic [7:0] regs_ff [NUM_REGS];
  logic [7:0] rdata_ff;
  logic fifo_ready;
  logic busy_ff;
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end
    else
    begin
      scl_sync_ff <= {scl_sync_ff[0], i_scl};
      sda_sync_ff <= {sda_sync_ff[0], i_sda};
      scl_ff <= scl_sync_ff[1];
      sda_ff <= sda_sync_ff[1];
    end
  end
  wire scl_s = scl_sync_ff[1];
  wire sda_s = sda_sync_ff[1];
  // line conditions; the master keeps the bus idle between frames
  wire start_det = scl_ff && scl_s && sda_ff && !sda_s;
  wire stop_det = scl_ff && scl_s && !sda_ff && sda_s;
  wire scl_rise = !scl_ff && scl_s;
  wire scl_fall = scl_ff && !scl_s;
  wire byte_done = scl_rise && (bitcnt_ff == BIT_LAST);
  wire ack_rise = scl_rise && (bitcnt_ff == ACK_SLOT);
  wire ack_end = scl_fall && (bitcnt_ff == ACK_SLOT);
  wire [7:0] rx_byte = {shift_ff[6:0], sda_s};
  wire [7:0] mode_config_one = regs_ff[REG_MODE_CONFIG_ONE];
  // address decode of the completed address byte
  wire [6:0] rx_addr = rx_byte[7:1];
  wire rx_read = rx_byte[0];
  wire hit_own = (rx_addr == SLAVE_ADDR);
  wire hit_bcast = mode_config_one[BIT_BCAST_EN] && (rx_addr == regs_ff[REG_BCAST][7:1]);
  wire hit_group_one_enable_bit = mode_config_one[BIT_GROUP_ONE_ENABLE_BIT_EN] && (rx_addr == regs_ff[REG_GROUP_ONE_ENABLE_BIT][7:1]);
  wire hit_group_two_enable_bit = mode_config_one[BIT_GROUP_TWO_ENABLE_BIT_EN] && (rx_addr == regs_ff[REG_GROUP_TWO_ENABLE_BIT][7:1]);
  wire hit_group_three_enable_bit = mode_config_one[BIT_GROUP_THREE_ENABLE_BIT_EN] && (rx_addr == regs_ff[REG_GROUP_THREE_ENABLE_BIT][7:1]);
  wire hit_any = hit_own || hit_bcast || hit_group_one_enable_bit || hit_group_two_enable_bit || hit_group_three_enable_bit;
  wire hit_soft = (rx_addr == SOFT_RESET_ADDR) && !rx_read;
  // pointer step by option; above-range runs up to last register first
  wire [4:0] ptr = ctrl_ff[4:0];
  wire [2:0] opt = ctrl_ff[7:5];
  wire [4:0] ptr_inc = ptr + 5'h01;
  wire ptr_top = (ptr == REG_LAST);
  logic [4:0] nxt_ptr;
  always_comb
  begin
    nxt_ptr = ptr;
    case (opt)
      INC_ALL: nxt_ptr = ptr_top ? REG_MODE_CONFIG_ONE : ptr_inc;
      INC_DUTY: nxt_ptr = ptr_top ? REG_MODE_CONFIG_ONE :
        (ptr == REG_DUTY_LAST) ? REG_DUTY_FIRST : ptr_inc;
      INC_GRP: nxt_ptr = ptr_top ? REG_MODE_CONFIG_ONE :
        (ptr == REG_GRP_LAST) ? REG_GRP_FIRST : ptr_inc;
      INC_DUTY_GRP: nxt_ptr = ptr_top ? REG_MODE_CONFIG_ONE :
        (ptr == REG_GRP_LAST) ? REG_DUTY_FIRST : ptr_inc;
      default: nxt_ptr = ptr;
    endcase
  end
  // reserved options fall to the hold branch above
  wire step_ptr = ctrl_ff[BIT_INC_EN];
  // ack decision made when the eighth bit arrives
  logic want_ack;
  always_comb
  begin
    want_ack = 1'b0;
    nxt_state = state_ff;
    case (state_ff)
      ST_ADDR:
      begin
        want_ack = hit_any || hit_soft;
        if (hit_soft && !hit_any)
          nxt_state = ST_KEY1;
        else if (hit_any)
          nxt_state = rx_read ? ST_RDATA : ST_CTRL;
        else
          nxt_state = ST_IGNORE;
      end
      ST_CTRL:
      begin
        want_ack = 1'b1;
        nxt_state = ST_WDATA;
      end
      ST_WDATA:
      begin
        want_ack = fifo_ready; // a full fifo answers nack
        nxt_state = ST_WDATA;
      end
      ST_KEY1:
      begin
        want_ack = (rx_byte == SOFT_KEY_ONE);
        nxt_state = want_ack ? ST_KEY2 : ST_IGNORE;
      end
      ST_KEY2:
      begin
        want_ack = (rx_byte == SOFT_KEY_TWO);
        nxt_state = want_ack ? ST_KEYDONE : ST_IGNORE;
      end
      ST_KEYDONE:
      begin
        want_ack = 1'b0;
        nxt_state = ST_IGNORE;
      end
      ST_RDATA: nxt_state = ST_RDATA;
      ST_IGNORE: nxt_state = ST_IGNORE;
      ST_IDLE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end
  wire wr_push = byte_done && (state_ff == ST_WDATA) && fifo_ready;
  // bus sequencer
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      state_ff <= ST_IDLE;
      bitcnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ack_ff <= 1'b0;
      soft_armed_ff <= 1'b0;
      busy_ff <= 1'b0;
    end
    else if (start_det)
    begin
      state_ff <= ST_ADDR;
      bitcnt_ff <= 4'h0;
      ack_ff <= 1'b0;
      soft_armed_ff <= 1'b0;
      busy_ff <= 1'b1;
    end
    else if (stop_det)
    begin
      state_ff <= ST_IDLE;
      ack_ff <= 1'b0;
      busy_ff <= 1'b0;
      soft_armed_ff <= 1'b0;
    end
    else if (state_ff != ST_IDLE)
    begin
      if (scl_rise && bitcnt_ff < ACK_SLOT)
        shift_ff <= rx_byte;
      if (byte_done && state_ff != ST_RDATA)
      begin
        ack_ff <= want_ack;
        state_ff <= nxt_state;
        soft_armed_ff <= (state_ff == ST_KEY2) && want_ack;
      end
      if (byte_done && state_ff == ST_KEYDONE)
        soft_armed_ff <= 1'b0; // a third byte cancels the call
      if (scl_rise)
        bitcnt_ff <= (bitcnt_ff == ACK_SLOT) ? 4'h0 : bitcnt_ff + 4'h1;
      if (ack_rise)
        ack_ff <= 1'b0; // kept to the ninth rise so reads can tell the address slot
    end
  end
  // soft reset fires on stop after both keys
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      soft_req_ff <= 1'b0;
    else
      soft_req_ff <= stop_det && soft_armed_ff && (state_ff == ST_KEYDONE);
  end
  wire clr = !i_nrst || soft_req_ff;
  // control byte and pointer stepping
  wire rd_take = ack_rise && state_ff == ST_RDATA && !ack_ff;
  always_ff @(posedge i_clk)
  begin
    if (clr)
      ctrl_ff <= RST_ZERO;
    else if (byte_done && state_ff == ST_CTRL)
      ctrl_ff <= rx_byte;
    else if ((wr_push || rd_take) && step_ptr)
      ctrl_ff <= {ctrl_ff[7:5], nxt_ptr};
  end
  // local register copy; one generate lane per register
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++)
    begin : g_reg
      localparam logic [4:0] IDX = 5'(gi);
      localparam logic [7:0] RST = (IDX == REG_MODE_CONFIG_ONE) ? RST_MODE_CONFIG_ONE :
        (IDX == REG_GROUP_ONE_ENABLE_BIT) ? RST_GROUP_ONE_ENABLE_BIT : (IDX == REG_GROUP_TWO_ENABLE_BIT) ? RST_GROUP_TWO_ENABLE_BIT :
        (IDX == REG_GROUP_THREE_ENABLE_BIT) ? RST_GROUP_THREE_ENABLE_BIT : (IDX == REG_BCAST) ? RST_BCAST : RST_ZERO;
      always_ff @(posedge i_clk)
      begin
        if (clr)
          regs_ff[gi] <= RST;
        else if (wr_push && ptr == IDX && IDX <= REG_LAST)
          regs_ff[gi] <= rx_byte;
      end
    end
  endgenerate
  // read side events: address slot rise, data bit falls, fall that ends the ack slot
  wire rd_first = ack_rise && (state_ff == ST_RDATA) && ack_ff;
  wire [4:0] rd_next = step_ptr ? nxt_ptr : ptr;
  wire rd_state = (state_ff == ST_RDATA);
  wire bit_fall = scl_fall && (bitcnt_ff != 4'h0) && (bitcnt_ff <= BIT_LAST);
  wire slot_fall = scl_fall && (bitcnt_ff == 4'h0);
  // byte loads at the ninth rise; each bit changes only while scl is low
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      rdata_ff <= 8'h00;
      rd_ack_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end
    else if (start_det || stop_det)
    begin
      rd_ack_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end
    else
    begin
      if (rd_first)
      begin
        rd_ack_ff <= 1'b1;
        rdata_ff <= regs_ff[ptr];
      end
      else if (rd_take)
      begin
        rd_ack_ff <= !sda_s;
        rdata_ff <= regs_ff[rd_next];
      end
      else if (bit_fall && rd_state)
        rdata_ff <= {rdata_ff[6:0], 1'b0};
      // ack_ff is never set for read data bytes, so the master owns that slot
      if (ack_end)
        sda_oe_ff <= ack_ff;
      else if (slot_fall)
        sda_oe_ff <= rd_state && rd_ack_ff && !rdata_ff[7];
      else if (bit_fall && rd_state)
        sda_oe_ff <= rd_ack_ff && !rdata_ff[6];
    end
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      o_busy <= 1'b0;
    else
      o_busy <= busy_ff;
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      o_sda <= 1'b0;
      o_sda_oe <= 1'b0;
      o_mode_config_one <= RST_MODE_CONFIG_ONE;
    end
    else
    begin
      o_sda <= 1'b0;
      o_sda_oe <= sda_oe_ff;
      o_mode_config_one <= regs_ff[REG_MODE_CONFIG_ONE];
    end
  end
  // written bytes leave through the fifo; sink stall makes us nack
  lds_fifo #(
    .WIDTH(13),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_valid(wr_push),
    .o_ready(fifo_ready),
    .i_data({ptr, rx_byte}),
    .o_valid(o_wr_valid),
    .i_ready(i_wr_ready),
    .o_data({o_wr_addr, o_wr_data})
  );
endmodule

// ===== test/lds_bus_master.sv
`timescale 1ns/1ns
module lds_bus_master (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  // bus rests released, clock stands still between frames
  initial
  begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end

  // quarter of a 320 ns bit period
  task automatic qt();
    repeat (2) @(posedge i_clk);
  endtask

  // data moves only in the low phase, sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    o_sda_oe <= ~b;
    qt();
    o_scl <= 1'b1;
    qt();
    qt();
    r = i_sda;
    o_scl <= 1'b0;
    qt();
  endtask

  // also serves as repeated start from a low clock
  task automatic start_c();
    o_sda_oe <= 1'b0;
    qt();
    o_scl <= 1'b1;
    qt();
    o_sda_oe <= 1'b1;
    qt();
    o_scl <= 1'b0;
    qt();
  endtask

  task automatic stop_c();
    o_sda_oe <= 1'b1;
    qt();
    o_scl <= 1'b1;
    qt();
    o_sda_oe <= 1'b0;
    qt();
  endtask

  // msb first, then the ack slot clocked by us
  task automatic wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // last byte is left unacknowledged
  task automatic rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule

// ===== test/lds_slave_monitor.sv
`timescale 1ns/1ns
module lds_slave_chk
  import lds_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic o_wr_valid,
  input wire logic [4:0] o_wr_addr,
  input wire logic [7:0] o_wr_data,
  input wire logic i_wr_ready,
  input wire logic [7:0] o_mode_config_one,
  input wire logic o_busy
);
  // one clock domain only
  default clocking cb @(posedge i_clk);
  endclocking

  // reset state has to be visible right after a reset edge
  chk_reset_vals: assert property (!i_nrst |=> o_mode_config_one == RST_MODE_CONFIG_ONE
    && !o_sda_oe && !o_wr_valid && !o_busy) else $error("reset state wrong");
  chk_idle_release: assert property (disable iff (!i_nrst)
    !o_busy |-> !o_sda_oe) else $error("sda pulled outside a transfer");
  chk_start_busy: assert property (disable iff (!i_nrst)
    $fell(i_sda) && i_scl && $past(i_scl) |-> ##[1:8] o_busy) else $error("start missed");
  chk_stop_idle: assert property (disable iff (!i_nrst)
    $rose(i_sda) && i_scl && $past(i_scl) |-> ##[1:8] !o_busy) else $error("stop missed");
  chk_stream_hold: assert property (disable iff (!i_nrst)
    o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_addr) && $stable(o_wr_data))
    else $error("stream changed while stalled");
  // a pull must last most of a bit period, or the master samples a glitch
  chk_ack_width: assert property (disable iff (!i_nrst)
    $rose(o_sda_oe) |-> o_sda_oe [*6]) else $error("sda pull too short");
  chk_drive_level: assert property (disable iff (!i_nrst)
    o_sda_oe |-> !o_sda) else $error("open drain drives high");
  // edges on sda with scl high would read as start or stop
  chk_oe_on_low: assert property (disable iff (!i_nrst)
    $rose(o_sda_oe) |-> !$past(i_scl, 2)) else $error("pull began with scl high");
  chk_oe_off_low: assert property (disable iff (!i_nrst)
    $fell(o_sda_oe) |-> !$past(i_scl, 2)) else $error("release with scl high");
endmodule

bind lds_slave lds_slave_chk u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_scl(i_scl),
  .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_wr_valid(o_wr_valid),
  .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .i_wr_ready(i_wr_ready),
  .o_mode_config_one(o_mode_config_one), .o_busy(o_busy));

// ===== test/lds_slave_test.sv
`timescale 1ns/1ns
module lds_slave_test
  import lds_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic k;} lds_row_s;
  typedef struct packed {logic [7:0] c; logic [3:0] n;} lds_opt_s;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_wr_ready = 1'b1;
  logic scl, m_oe, o_sda, o_sda_oe, o_wr_valid, o_busy;
  logic [4:0] o_wr_addr;
  logic [7:0] o_wr_data, o_mode_config_one;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [12:0] q[$];
  // address byte and whether it must be acknowledged; soft reset never reused
  lds_row_s ar[12] = '{'{8'hc0, 1'b1}, '{8'hc1, 1'b1}, '{8'hd0, 1'b1}, '{8'hd1, 1'b1},
    '{8'hd2, 1'b0}, '{8'hd3, 1'b0}, '{8'hd4, 1'b0}, '{8'hd5, 1'b0}, '{8'hd8, 1'b0},
    '{8'hd9, 1'b0}, '{8'hd7, 1'b0}, '{8'h42, 1'b0}};
  lds_row_s gr[4] = '{'{8'hd2, 1'b1}, '{8'hd4, 1'b0}, '{8'hd8, 1'b0}, '{8'hd0, 1'b1}};
  // control byte and data byte count; reserved options never sent
  lds_opt_s orow[6] = '{'{8'h05, 4'h3}, '{8'h9b, 4'h3}, '{8'hb1, 4'h3}, '{8'hd3, 4'h3},
    '{8'hf3, 4'h3}, '{8'hf4, 4'h9}};
  // pull-up plus open-drain pulls from both parties
  wire sda = ~(m_oe | (o_sda_oe & ~o_sda));

  always #20 i_clk = ~i_clk;

  lds_bus_master m (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
  lds_slave #(.SLAVE_ADDR(7'h60), .FIFO_DEPTH(8)) dut (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_scl(scl), .i_sda(sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_wr_valid(o_wr_valid),
    .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .i_wr_ready(i_wr_ready),
    .o_mode_config_one(o_mode_config_one), .o_busy(o_busy));

  // capture the register stream as the sink takes it
  always @(posedge i_clk)
    if (o_wr_valid === 1'b1 && i_wr_ready) q.push_back({o_wr_addr, o_wr_data});

  // pointer walk worked out independently
  function automatic logic [4:0] step(input logic [4:0] p, input logic [2:0] o);
    logic [4:0] hi, lo;
    hi = (o == 3'h4) ? 5'h1b : (o == 3'h5) ? 5'h11 : 5'h13;
    lo = (o == 3'h4) ? 5'h00 : (o == 3'h6) ? 5'h12 : 5'h02;
    if (!o[2]) return p;
    if (p == hi) return lo;
    return (p == 5'h1b) ? 5'h00 : p + 5'h01;
  endfunction

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic send(input logic [7:0] b, input logic e);
    logic k;
    m.wr(b, k);
    chk("ack", {12'h0, e}, {12'h0, k});
  endtask

  // bounded wait for n stream entries, then compare the pointer walk
  task automatic drain(input int n, input logic [4:0] p, input logic [2:0] o,
    input logic [7:0] d);
    int t;
    for (t = 0; t < 400 && q.size() < n; t++)
      @(posedge i_clk);
    if (q.size() < n)
    begin
      error_cnt++;
      conclude();
    end
    for (t = 0; t < n; t++)
    begin
      chk("stream", {p, d + 8'(t)}, q.pop_front());
      p = step(p, o);
    end
  endtask

  initial
  begin
    logic [7:0] d;
    logic k;
    int cnt;
    repeat (20) @(posedge i_clk);
    chk("rst", {4'h0, RST_MODE_CONFIG_ONE, 1'b0}, {4'h0, o_mode_config_one, o_sda_oe | o_busy});
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk);
    foreach (ar[i])
    begin
      m.start_c();
      send(ar[i].a, ar[i].k);
      if (ar[i].k && ar[i].a[0])
      begin
        m.rd(1'b1, d);
        chk("rdata", {5'h0, RST_MODE_CONFIG_ONE}, {5'h0, d});
      end
      m.stop_c();
    end
    $display("done address decode");
    foreach (orow[i])
    begin
      m.start_c();
      send(8'hc0, 1'b1);
      send(orow[i].c, 1'b1);
      for (int j = 0; j < orow[i].n; j++)
        send(8'h30 + 8'(j), 1'b1);
      m.stop_c();
      drain(orow[i].n, orow[i].c[4:0], orow[i].c[7:5], 8'h30);
    end
    $display("done pointer options");
    // stalled sink: bytes are refused once the buffer is full
    i_wr_ready <= 1'b0;
    m.start_c();
    send(8'hc0, 1'b1);
    send(8'h05, 1'b1);
    cnt = 0;
    k = 1'b1;
    while (k && cnt < 12)
    begin
      m.wr(8'h60 + 8'(cnt), k);
      if (k) cnt++;
    end
    m.stop_c();
    chk("fill", 13'h1, {12'h0, cnt >= 8 && cnt <= 9});
    i_wr_ready <= 1'b1;
    drain(cnt, 5'h05, 3'h0, 8'h60);
    $display("done buffer");
    m.start_c();
    send(8'hc0, 1'b1);
    send(8'h86, 1'b1);
    send(8'h5c, 1'b1);
    send(8'h5d, 1'b1);
    m.start_c();
    send(8'hc0, 1'b1);
    send(8'h86, 1'b1);
    m.start_c();
    send(8'hc1, 1'b1);
    m.rd(1'b0, d);
    chk("rd0", 13'h5c, {5'h0, d});
    m.rd(1'b1, d);
    chk("rd1", 13'h5d, {5'h0, d});
    m.stop_c();
    drain(2, 5'h06, 3'h4, 8'h5c);
    $display("done readback");
    m.start_c();
    send(8'hd6, 1'b1);
    send(8'ha5, 1'b1);
    send(8'h33, 1'b0);
    m.stop_c();
    repeat (10) @(posedge i_clk);
    chk("mode", 13'h38, {5'h0, o_mode_config_one});
    m.start_c();
    send(8'hd6, 1'b1);
    send(8'ha5, 1'b1);
    send(8'h5a, 1'b1);
    m.stop_c();
    repeat (10) @(posedge i_clk);
    chk("mode", {5'h0, RST_MODE_CONFIG_ONE}, {5'h0, o_mode_config_one});
    m.start_c();
    send(8'hd2, 1'b0);
    m.stop_c();
    $display("done soft reset");
    m.start_c();
    send(8'hc0, 1'b1);
    send(8'h00, 1'b1);
    send(8'h09, 1'b1);
    m.stop_c();
    drain(1, 5'h00, 3'h0, 8'h09);
    chk("mode", 13'h09, {5'h0, o_mode_config_one});
    foreach (gr[i])
    begin
      m.start_c();
      send(gr[i].a, gr[i].k);
      m.stop_c();
    end
    $display("done group enables");
    conclude();
  end
endmodule
